//--- verilog/ccd_params.svh
// Offsets, field positions, reset values and counts of the execution unit
`ifndef CCD_PARAMS_SVH
`define CCD_PARAMS_SVH
// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define CCD_OFS_INSTR 8'h00
`define CCD_OFS_WORK 8'h04
`define CCD_OFS_LATCH_HIGH 8'h08
`define CCD_OFS_PC 8'h0C
`define CCD_OFS_STATUS 8'h10
`define CCD_OFS_STACK_TOP 8'h14
`define CCD_OFS_WATCHDOG 8'h18
`define CCD_OFS_FILE_PTR 8'h1C
`define CCD_OFS_FILE_DATA 8'h20
// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CCD_INSTR_OP_LSB 0
`define CCD_INSTR_DEST_BIT 7
`define CCD_INSTR_FILE_LSB 8
`define CCD_STAT_ZERO_BIT 0
`define CCD_STAT_PD_BIT 1
`define CCD_STAT_TO_BIT 2
`define CCD_STAT_BUSY_BIT 3
`define CCD_STAT_SECOND_BIT 4
`define CCD_WDT_COUNT_LSB 0
`define CCD_WDT_PRESC_LSB 16
// ----------------------------------------------------------------
// Reset values, responses and counts
// ----------------------------------------------------------------
`define CCD_RST_WORK 8'h00
`define CCD_RST_LATCH_HIGH 7'h00
`define CCD_RST_PC 15'h0000
`define CCD_RST_STACK_TOP 15'h0000
`define CCD_RST_ZERO 1'h0
`define CCD_RST_TO 1'h1
`define CCD_RST_PD 1'h1
`define CCD_RESP_OKAY 2'h0
`define CCD_RESP_SLVERR 2'h2
`define CCD_CYCLE_CLOCKS 4
`endif

//--- verilog/ccd_pkg.sv
// Types shared by the execution unit files
package ccd_pkg;
   // Instruction codes, 3'h7 is illegal and runs as a no-operation
   typedef enum logic [2:0] {
      CCD_CALL_VIA_WORKING_REG = 3'h0,
      CCD_CLEAR_FILE_OP = 3'h1,
      CCD_CLEAR_WORKING_OP = 3'h2,
      CCD_WATCHDOG_CLEAR_OP = 3'h3,
      CCD_COMPLEMENT_FILE_OP = 3'h4,
      CCD_DECREMENT_FILE_OP = 3'h5,
      CCD_DECREMENT_SKIP_ZERO_OP = 3'h6,
      CCD_NO_OPERATION = 3'h7
   } ccd_op_type;
   // Latched instruction word
   typedef struct packed {
      logic [6:0] faddr;
      logic dest;
      ccd_op_type op;
   } ccd_instr_type;
   // Execution sequencer states
   typedef enum logic [1:0] {
      CCD_IDLE = 2'h0,
      CCD_FIRST = 2'h1,
      CCD_SECOND = 2'h2
   } ccd_state_type;
   // One register access handed from the bus slave
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] waddr;
      logic [7:0] raddr;
      logic [31:0] wdata;
      logic [3:0] wstrb;
   } ccd_req_type;
endpackage : ccd_pkg

//--- verilog/ccd_cycle_tick.sv
// Instruction cycle enable divider
`timescale 1ns/1ps
module ccd_cycle_tick #(
   parameter int CYCLE_CLOCKS = 4
) (
   input wire logic i_clock,
   input wire logic i_rst_n,
   output logic o_tick
);
   localparam int CW = (CYCLE_CLOCKS < 2) ? 1 : $clog2(CYCLE_CLOCKS);
   if (CYCLE_CLOCKS < 1) begin : g_bad
      $error("CYCLE_CLOCKS must be at least 1");
   end
   logic [CW-1:0] count;
   wire last = (count == CW'(CYCLE_CLOCKS - 1));
   // Free running count, one pulse per instruction cycle
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         count <= '0;
         o_tick <= 1'h0;
      end else begin
         count <= last ? '0 : CW'(count + 1'h1);
         o_tick <= last;
      end
   end
endmodule : ccd_cycle_tick

//--- verilog/ccd_axil_slave.sv
// AXI4-Lite slave front end handing single register accesses inward
`timescale 1ns/1ps
`include "ccd_params.svh"
module ccd_axil_slave
   import ccd_pkg::*;
(
   input wire logic i_clock,
   input wire logic i_rst_n,
   input wire logic [7:0] i_awaddr,
   input wire logic i_awvalid,
   output logic o_awready,
   input wire logic [31:0] i_wdata,
   input wire logic [3:0] i_wstrb,
   input wire logic i_wvalid,
   output logic o_wready,
   output logic [1:0] o_bresp,
   output logic o_bvalid,
   input wire logic i_bready,
   input wire logic [7:0] i_araddr,
   input wire logic i_arvalid,
   output logic o_arready,
   output logic [31:0] o_rdata,
   output logic [1:0] o_rresp,
   output logic o_rvalid,
   input wire logic i_rready,
   output ccd_req_type o_req,
   input wire logic [31:0] i_rdata,
   input wire logic i_wr_hit,
   input wire logic i_rd_hit
);
   logic aw_full;
   logic w_full;
   logic rd_pend;
   logic [7:0] waddr;
   logic [7:0] raddr;
   logic [31:0] wdata;
   logic [3:0] wstrb;
   // Handshakes and next occupancy
   wire aw_take = i_awvalid && o_awready;
   wire w_take = i_wvalid && o_wready;
   wire ar_take = i_arvalid && o_arready;
   wire wr = aw_full && w_full && !o_bvalid;
   wire next_aw_full = aw_take || (aw_full && !wr);
   wire next_w_full = w_take || (w_full && !wr);
   wire next_bvalid = wr || (o_bvalid && !i_bready);
   wire next_rvalid = rd_pend || (o_rvalid && !i_rready);
   assign o_req = '{wr: wr, rd: rd_pend, waddr: waddr, raddr: raddr,
                    wdata: wdata, wstrb: wstrb};
   // Channel state, one write and one read outstanding
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         {aw_full, w_full, rd_pend, o_bvalid, o_rvalid} <= 5'h00;
         {o_awready, o_wready, o_arready} <= 3'h0;
         {waddr, raddr, wstrb} <= 20'h00000;
         wdata <= 32'h00000000;
         o_rdata <= 32'h00000000;
         o_bresp <= `CCD_RESP_OKAY;
         o_rresp <= `CCD_RESP_OKAY;
      end else begin
         aw_full <= next_aw_full;
         w_full <= next_w_full;
         o_bvalid <= next_bvalid;
         o_awready <= !next_aw_full && !next_bvalid;
         o_wready <= !next_w_full && !next_bvalid;
         rd_pend <= ar_take;
         o_rvalid <= next_rvalid;
         o_arready <= !ar_take && !next_rvalid;
         if (aw_take) waddr <= i_awaddr;
         if (w_take) begin
            wdata <= i_wdata;
            wstrb <= i_wstrb;
         end
         if (ar_take) raddr <= i_araddr;
         if (wr) o_bresp <= i_wr_hit ? `CCD_RESP_OKAY : `CCD_RESP_SLVERR;
         if (rd_pend) begin
            o_rdata <= i_rdata;
            o_rresp <= i_rd_hit ? `CCD_RESP_OKAY : `CCD_RESP_SLVERR;
         end
      end
   end
endmodule : ccd_axil_slave

//--- verilog/ccd_exec_core.sv
// Execution unit for call, clear, complement and decrement instructions
`timescale 1ns/1ps
// ----------------------------------------------------------------
// ----------------------------------------------------------------
`include "ccd_params.svh"
module ccd_exec_core
   import ccd_pkg::*;
#(
   parameter int CYCLE_CLOCKS = `CCD_CYCLE_CLOCKS,
   parameter int PRESCALE_WIDTH = 8,
   parameter int WATCHDOG_WIDTH = 8
) (
   input wire logic i_clock,
   input wire logic i_rst_n,
   input wire logic [7:0] i_awaddr,
   input wire logic i_awvalid,
   output logic o_awready,
   input wire logic [31:0] i_wdata,
   input wire logic [3:0] i_wstrb,
   input wire logic i_wvalid,
   output logic o_wready,
   output logic [1:0] o_bresp,
   output logic o_bvalid,
   input wire logic i_bready,
   input wire logic [7:0] i_araddr,
   input wire logic i_arvalid,
   output logic o_arready,
   output logic [31:0] o_rdata,
   output logic [1:0] o_rresp,
   output logic o_rvalid,
   input wire logic i_rready,
   output logic [14:0] o_pc,
   output logic [14:0] o_top_of_stack,
   output logic o_busy
);
   // ----------------------------------------------------------------
   // Parameter checks
   // ----------------------------------------------------------------
   if (PRESCALE_WIDTH < 1 || PRESCALE_WIDTH > 16) begin : g_bad_presc
      $error("PRESCALE_WIDTH must be 1 to 16");
   end
   if (WATCHDOG_WIDTH < 1 || WATCHDOG_WIDTH > 16) begin : g_bad_wdt
      $error("WATCHDOG_WIDTH must be 1 to 16");
   end

   // ----------------------------------------------------------------
   // Reset release and instruction cycle enable
   // ----------------------------------------------------------------
   logic rst_meta;
   logic rst_n;
   logic tick;
   // Two stage release of the asynchronous reset
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rst_meta <= 1'h0;
         rst_n <= 1'h0;
      end else begin
         rst_meta <= 1'h1;
         rst_n <= rst_meta;
      end
   end

   ccd_cycle_tick #(
      .CYCLE_CLOCKS(CYCLE_CLOCKS)
   ) u_tick (
      .i_clock(i_clock),
      .i_rst_n(rst_n),
      .o_tick(tick)
   );

   // ----------------------------------------------------------------
   // Bus front end
   // ----------------------------------------------------------------
   ccd_req_type req;
   logic [31:0] rdata;
   logic wr_hit;
   logic rd_hit;

   ccd_axil_slave u_bus (
      .i_clock(i_clock),
      .i_rst_n(rst_n),
      .i_awaddr(i_awaddr),
      .i_awvalid(i_awvalid),
      .o_awready(o_awready),
      .i_wdata(i_wdata),
      .i_wstrb(i_wstrb),
      .i_wvalid(i_wvalid),
      .o_wready(o_wready),
      .o_bresp(o_bresp),
      .o_bvalid(o_bvalid),
      .i_bready(i_bready),
      .i_araddr(i_araddr),
      .i_arvalid(i_arvalid),
      .o_arready(o_arready),
      .o_rdata(o_rdata),
      .o_rresp(o_rresp),
      .o_rvalid(o_rvalid),
      .i_rready(i_rready),
      .o_req(req),
      .i_rdata(rdata),
      .i_wr_hit(wr_hit),
      .i_rd_hit(rd_hit)
   );

   // Byte lane merge of a write into an old value
   function automatic logic [31:0] ccd_merge(input logic [31:0] old,
                                             input logic [31:0] data,
                                             input logic [3:0] strb);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) res[8*i +: 8] = data[8*i +: 8];
      end
      return res;
   endfunction : ccd_merge

   // ----------------------------------------------------------------
   // Core state
   // ----------------------------------------------------------------
   ccd_state_type state;
   ccd_instr_type instr;
   logic [7:0] work;
   logic [6:0] latch_high;
   logic [14:0] pc;
   logic zero_flag;
   logic time_out_flag;
   logic power_down_flag;
   logic [PRESCALE_WIDTH-1:0] presc;
   logic [WATCHDOG_WIDTH-1:0] wdt;
   logic [6:0] file_ptr;
   logic [7:0] file_mem [0:127];

   // Write decode, bus writes other than the file pointer only take effect while idle
   wire idle = (state == CCD_IDLE);
   wire w_instr = req.wr && req.waddr == `CCD_OFS_INSTR;
   wire w_work = req.wr && req.waddr == `CCD_OFS_WORK && idle;
   wire w_latch = req.wr && req.waddr == `CCD_OFS_LATCH_HIGH && idle;
   wire w_pc = req.wr && req.waddr == `CCD_OFS_PC && idle;
   wire w_ptr = req.wr && req.waddr == `CCD_OFS_FILE_PTR;
   wire w_file = req.wr && req.waddr == `CCD_OFS_FILE_DATA && idle;
   wire issue = w_instr && idle;
   wire [31:0] m_work = ccd_merge({24'h000000, work}, req.wdata, req.wstrb);
   wire [31:0] m_latch = ccd_merge({25'h0000000, latch_high}, req.wdata, req.wstrb);
   wire [31:0] m_pc = ccd_merge({17'h00000, pc}, req.wdata, req.wstrb);
   wire [31:0] m_ptr = ccd_merge({25'h0000000, file_ptr}, req.wdata, req.wstrb);
   wire [7:0] bus_file = req.wstrb[0] ? req.wdata[7:0] : file_mem[file_ptr];
   wire [31:0] new_instr = req.wdata;

   // ----------------------------------------------------------------
   // Execution datapath
   // ----------------------------------------------------------------
   wire exec = (state == CCD_FIRST) && tick;
   wire [7:0] file_val = file_mem[instr.faddr];
   wire op_call = (instr.op == CCD_CALL_VIA_WORKING_REG);
   wire op_clear_file_op = (instr.op == CCD_CLEAR_FILE_OP);
   wire op_clear_working_op = (instr.op == CCD_CLEAR_WORKING_OP);
   wire op_wdt = (instr.op == CCD_WATCHDOG_CLEAR_OP);
   wire op_com = (instr.op == CCD_COMPLEMENT_FILE_OP);
   wire op_dec = (instr.op == CCD_DECREMENT_FILE_OP);
   wire op_dsz = (instr.op == CCD_DECREMENT_SKIP_ZERO_OP);
   wire op_alu = op_com || op_dec || op_dsz;
   // Inverse or value minus one of the addressed file register
   wire [7:0] result = op_com ? ~file_val : 8'(file_val - 8'h01);
   wire result_zero = (result == 8'h00);
   wire skip = op_dsz && result_zero;
   wire two_cycle = op_call || skip;
   wire [14:0] pc_next1 = 15'(pc + 15'h0001);
   wire [14:0] pc_next2 = 15'(pc + 15'h0002);
   // Destination select: 0 to working register, 1 back to file
   wire to_work = op_alu && !instr.dest;
   wire to_file = op_alu && instr.dest;

   // Next working register value
   wire [7:0] next_work = (exec && op_clear_working_op) ? 8'h00 :
                          (exec && to_work) ? result :
                          w_work ? m_work[7:0] : work;
   // Next program counter, call loads {latch high, working}
   wire [14:0] next_pc = (exec && op_call) ? {latch_high, work} :
                         (exec && skip) ? pc_next2 :
                         exec ? pc_next1 :
                         w_pc ? m_pc[14:0] : pc;
   // Return address pushed first by the call
   wire [14:0] next_tos = (exec && op_call) ? pc_next1 : o_top_of_stack;
   // Zero flag: set by clears, from result on complement and decrement, kept on decrement-skip-zero
   wire next_zero = (exec && (op_clear_file_op || op_clear_working_op)) ? 1'h1 :
                    (exec && (op_com || op_dec)) ? result_zero :
                    zero_flag;

   // File write port shared by execution and bus
   wire x_file_we = exec && (op_clear_file_op || to_file);
   wire mem_we = x_file_we || w_file;
   wire [6:0] mem_addr = x_file_we ? instr.faddr : file_ptr;
   wire [7:0] mem_data = x_file_we ? (op_clear_file_op ? 8'h00 : result) : bus_file;

   // Watchdog: prescaler counts cycles, counter counts prescaler wraps
   wire wdt_clear = exec && op_wdt;
   wire presc_wrap = tick && (&presc);
   wire wdt_over = presc_wrap && (&wdt);
   wire [PRESCALE_WIDTH-1:0] next_presc =
      wdt_clear ? '0 : tick ? PRESCALE_WIDTH'(presc + 1'h1) : presc;
   wire [WATCHDOG_WIDTH-1:0] next_wdt =
      wdt_clear ? '0 : presc_wrap ? WATCHDOG_WIDTH'(wdt + 1'h1) : wdt;
   // Clear wins over a time-out in the same cycle
   wire next_to = wdt_clear ? 1'h1 : wdt_over ? 1'h0 : time_out_flag;
   wire next_pd = wdt_clear ? 1'h1 : power_down_flag;

   // ----------------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------------
   ccd_state_type next_state;
   always_comb begin
      next_state = state;
      unique case (state)
         CCD_IDLE: begin
            if (issue) next_state = CCD_FIRST;
         end
         CCD_FIRST: begin
            if (tick) next_state = two_cycle ? CCD_SECOND : CCD_IDLE;
         end
         CCD_SECOND: begin
            if (tick) next_state = CCD_IDLE;
         end
         default: begin
            next_state = CCD_IDLE;
         end
      endcase
   end

   // State and instruction latch
   always_ff @(posedge i_clock or negedge rst_n) begin
      if (!rst_n) begin
         state <= CCD_IDLE;
         instr <= '{faddr: 7'h00, dest: 1'h0, op: CCD_NO_OPERATION};
         o_busy <= 1'h0;
      end else begin
         state <= next_state;
         o_busy <= (next_state != CCD_IDLE);
         if (issue) begin
            instr.op <= ccd_op_type'(new_instr[`CCD_INSTR_OP_LSB +: 3]);
            instr.dest <= new_instr[`CCD_INSTR_DEST_BIT];
            instr.faddr <= new_instr[`CCD_INSTR_FILE_LSB +: 7];
         end
      end
   end

   // Architectural registers
   always_ff @(posedge i_clock or negedge rst_n) begin
      if (!rst_n) begin
         work <= `CCD_RST_WORK;
         latch_high <= `CCD_RST_LATCH_HIGH;
         pc <= `CCD_RST_PC;
         o_pc <= `CCD_RST_PC;
         o_top_of_stack <= `CCD_RST_STACK_TOP;
         zero_flag <= `CCD_RST_ZERO;
         file_ptr <= 7'h00;
      end else begin
         work <= next_work;
         if (w_latch) latch_high <= m_latch[6:0];
         pc <= next_pc;
         o_pc <= next_pc;
         o_top_of_stack <= next_tos;
         zero_flag <= next_zero;
         if (w_ptr) file_ptr <= m_ptr[6:0];
      end
   end

   // Watchdog and power status
   always_ff @(posedge i_clock or negedge rst_n) begin
      if (!rst_n) begin
         presc <= '0;
         wdt <= '0;
         time_out_flag <= `CCD_RST_TO;
         power_down_flag <= `CCD_RST_PD;
      end else begin
         presc <= next_presc;
         wdt <= next_wdt;
         time_out_flag <= next_to;
         power_down_flag <= next_pd;
      end
   end

   // File registers, contents undefined until written
   always_ff @(posedge i_clock) begin
      if (mem_we) file_mem[mem_addr] <= mem_data;
   end

   // ----------------------------------------------------------------
   // Read decode
   // ----------------------------------------------------------------
   wire [31:0] r_instr = (32'(instr.op) << `CCD_INSTR_OP_LSB)
                       | (32'(instr.dest) << `CCD_INSTR_DEST_BIT)
                       | (32'(instr.faddr) << `CCD_INSTR_FILE_LSB);
   wire [31:0] r_status = (32'(zero_flag) << `CCD_STAT_ZERO_BIT)
                        | (32'(power_down_flag) << `CCD_STAT_PD_BIT)
                        | (32'(time_out_flag) << `CCD_STAT_TO_BIT)
                        | (32'(!idle) << `CCD_STAT_BUSY_BIT)
                        | (32'(state == CCD_SECOND) << `CCD_STAT_SECOND_BIT);
   wire [31:0] r_wdt = (32'(wdt) << `CCD_WDT_COUNT_LSB)
                     | (32'(presc) << `CCD_WDT_PRESC_LSB);
   wire [7:0] ra = req.raddr;
   wire [7:0] wa = req.waddr;
   assign rdata = (ra == `CCD_OFS_INSTR) ? r_instr :
                  (ra == `CCD_OFS_WORK) ? {24'h000000, work} :
                  (ra == `CCD_OFS_LATCH_HIGH) ? {25'h0000000, latch_high} :
                  (ra == `CCD_OFS_PC) ? {17'h00000, pc} :
                  (ra == `CCD_OFS_STATUS) ? r_status :
                  (ra == `CCD_OFS_STACK_TOP) ? {17'h00000, o_top_of_stack} :
                  (ra == `CCD_OFS_WATCHDOG) ? r_wdt :
                  (ra == `CCD_OFS_FILE_PTR) ? {25'h0000000, file_ptr} :
                  (ra == `CCD_OFS_FILE_DATA) ? {24'h000000, file_mem[file_ptr]} :
                  32'h00000000;
   assign rd_hit = (ra <= `CCD_OFS_FILE_DATA) && (ra[1:0] == 2'h0);
   // Status, stack top and watchdog are read only
   assign wr_hit = (wa <= `CCD_OFS_FILE_DATA) && (wa[1:0] == 2'h0)
                 && (wa != `CCD_OFS_STATUS) && (wa != `CCD_OFS_STACK_TOP)
                 && (wa != `CCD_OFS_WATCHDOG);
endmodule : ccd_exec_core

//--- bench/ccd_exec_core_props.sv
// Port-level assertions of the execution unit
`timescale 1ns/1ps
module ccd_exec_core_props #(
   parameter int CYCLE_CLOCKS = 4
) (
   input wire logic i_clock,
   input wire logic i_rst_n,
   input wire logic i_awvalid,
   input wire logic o_awready,
   input wire logic [1:0] o_bresp,
   input wire logic o_bvalid,
   input wire logic i_bready,
   input wire logic i_arvalid,
   input wire logic o_arready,
   input wire logic [31:0] o_rdata,
   input wire logic [1:0] o_rresp,
   input wire logic o_rvalid,
   input wire logic i_rready,
   input wire logic [14:0] o_pc,
   input wire logic [14:0] o_top_of_stack,
   input wire logic o_busy
);
   int busy_len;
   // ----------------------------------------------------------------
   // Helper logic and checks
   // ----------------------------------------------------------------
   // Count consecutive busy samples
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) busy_len <= 0;
      else busy_len <= o_busy ? busy_len + 1 : 0;
   end
   default clocking dc @(posedge i_clock); endclocking
   default disable iff (!i_rst_n);
   property p_tos_push;
      !$stable(o_top_of_stack) |-> o_top_of_stack == 15'($past(o_pc) + 15'h1);
   endproperty
   a_tos_push: assert property (p_tos_push)
      else $error("stack top is not old pc plus one");
   property p_pc_step;
      !$stable(o_pc) && $stable(o_top_of_stack) && $past(o_busy) |->
         o_pc == 15'($past(o_pc) + 15'h1) || o_pc == 15'($past(o_pc) + 15'h2);
   endproperty
   a_pc_step: assert property (p_pc_step)
      else $error("pc step is neither one nor two");
   property p_skip_two;
      $stable(o_top_of_stack) && o_pc == 15'($past(o_pc) + 15'h2) && $past(o_busy) |-> o_busy;
   endproperty
   a_skip_two: assert property (p_skip_two)
      else $error("skip did not hold a second cycle");
   property p_call_two;
      !$stable(o_top_of_stack) |-> o_busy [*2];
   endproperty
   a_call_two: assert property (p_call_two)
      else $error("call did not hold a second cycle");
   property p_busy_len;
      o_busy |-> busy_len <= 2 * CYCLE_CLOCKS;
   endproperty
   a_busy_len: assert property (p_busy_len)
      else $error("busy held too long");
   property p_b_hold;
      o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp);
   endproperty
   a_b_hold: assert property (p_b_hold)
      else $error("write response dropped early");
   property p_r_hold;
      o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata) && $stable(o_rresp);
   endproperty
   a_r_hold: assert property (p_r_hold)
      else $error("read data dropped early");
   property p_r_time;
      i_arvalid && o_arready |-> ##2 o_rvalid;
   endproperty
   a_r_time: assert property (p_r_time)
      else $error("read answer late");
   property p_aw_busy;
      i_awvalid && o_awready |=> !o_awready [*2];
   endproperty
   a_aw_busy: assert property (p_aw_busy)
      else $error("write address taken twice");
endmodule : ccd_exec_core_props
bind ccd_exec_core ccd_exec_core_props #(.CYCLE_CLOCKS(CYCLE_CLOCKS)) ccd_exec_core_props_i (
   .i_clock(i_clock), .i_rst_n(i_rst_n), .i_awvalid(i_awvalid), .o_awready(o_awready),
   .o_bresp(o_bresp), .o_bvalid(o_bvalid), .i_bready(i_bready), .i_arvalid(i_arvalid),
   .o_arready(o_arready), .o_rdata(o_rdata), .o_rresp(o_rresp), .o_rvalid(o_rvalid),
   .i_rready(i_rready), .o_pc(o_pc), .o_top_of_stack(o_top_of_stack), .o_busy(o_busy));

//--- bench/ccd_exec_core_tb.sv
// Self-checking bench for the execution unit
`timescale 1ns/1ps
`include "ccd_params.svh"
module ccd_exec_core_tb;
   import ccd_pkg::*;
   logic i_clock = 0, i_rst_n = 0, i_awvalid = 0, i_wvalid = 0, i_bready = 0;
   logic i_arvalid = 0, i_rready = 0, o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
   logic [7:0] i_awaddr = 0, i_araddr = 0, w, v, res;
   logic [31:0] i_wdata = 0, o_rdata;
   logic [3:0] i_wstrb = 4'hF;
   logic [1:0] o_bresp, o_rresp, wq[$];
   logic [14:0] o_pc, o_top_of_stack, pc, top_of_stack;
   logic [65:0] rq[$];
   logic [6:0] lh, fa;
   logic [2:0] op;
   logic o_busy, z, d;
   int bad_count = 0, total_checks = 0, k;
   integer seed = 32'h567E;
   // Clock
   always #4 i_clock = ~i_clock;
   ccd_exec_core #(.CYCLE_CLOCKS(2), .PRESCALE_WIDTH(8), .WATCHDOG_WIDTH(2)) ccd_exec_core_i (
      .i_clock(i_clock), .i_rst_n(i_rst_n), .i_awaddr(i_awaddr), .i_awvalid(i_awvalid),
      .o_awready(o_awready), .i_wdata(i_wdata), .i_wstrb(i_wstrb), .i_wvalid(i_wvalid),
      .o_wready(o_wready), .o_bresp(o_bresp), .o_bvalid(o_bvalid), .i_bready(i_bready),
      .i_araddr(i_araddr), .i_arvalid(i_arvalid), .o_arready(o_arready), .o_rdata(o_rdata),
      .o_rresp(o_rresp), .o_rvalid(o_rvalid), .i_rready(i_rready), .o_pc(o_pc),
      .o_top_of_stack(o_top_of_stack), .o_busy(o_busy));
   // ----------------------------------------------------------------
   // Compare, report and bus tasks
   // ----------------------------------------------------------------
   task automatic cmp_resp(input string s, input logic [1:0] e, input logic [1:0] g);
      total_checks++;
      if (g !== e) begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", s, e, g);
      end
   endtask : cmp_resp
   task automatic cmp_data(input logic [31:0] e, input logic [31:0] g, input logic [31:0] m);
      total_checks++;
      if ((g & m) !== (e & m)) begin
         bad_count++;
         $display("wrong value rdata expected %h seen %h", e & m, g & m);
      end
   endtask : cmp_data
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : report_and_stop
   task automatic hang_stop(input int n);
      if (n >= 50) begin
         bad_count++;
         report_and_stop();
      end
   endtask : hang_stop
   task automatic wr(input logic [7:0] a, input logic [31:0] dt,
                     input logic [1:0] r = `CCD_RESP_OKAY);
      int n;
      wq.push_back(r);
      @(posedge i_clock);
      {i_awaddr, i_wdata, i_awvalid, i_wvalid, i_bready} <= {a, dt, 3'h7};
      n = 0;
      do begin
         @(posedge i_clock);
         n++;
         if (o_awready) i_awvalid <= 1'b0;
         if (o_wready) i_wvalid <= 1'b0;
      end while (n < 50 && o_bvalid !== 1'b1);
      i_bready <= 1'b0;
      hang_stop(n);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = '1,
                     input logic [1:0] r = `CCD_RESP_OKAY);
      int n;
      rq.push_back({r, e, m});
      @(posedge i_clock);
      {i_araddr, i_arvalid, i_rready} <= {a, 2'h3};
      n = 0;
      do begin
         @(posedge i_clock);
         n++;
         if (o_arready) i_arvalid <= 1'b0;
      end while (n < 50 && o_rvalid !== 1'b1);
      i_rready <= 1'b0;
      hang_stop(n);
   endtask : rd
   task automatic wait_idle;
      int n;
      for (n = 0; n < 50 && o_busy !== 1'b0; n++) @(posedge i_clock);
      hang_stop(n);
   endtask : wait_idle
   // Response watcher takes the oldest note at each handshake
   always @(posedge i_clock) begin
      if (o_bvalid === 1'b1 && i_bready === 1'b1) cmp_resp("bresp", wq.pop_front(), o_bresp);
      if (o_rvalid === 1'b1 && i_rready === 1'b1) begin
         cmp_resp("rresp", rq[0][65:64], o_rresp);
         cmp_data(rq[0][63:32], o_rdata, rq[0][31:0]);
         void'(rq.pop_front());
      end
   end
   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (12) @(posedge i_clock);
      i_rst_n <= 1'b1;
      repeat (3) @(posedge i_clock);
      // Reset values and refused accesses
      rd(`CCD_OFS_WORK, 32'(`CCD_RST_WORK));
      rd(`CCD_OFS_PC, 32'(`CCD_RST_PC));
      rd(`CCD_OFS_STACK_TOP, 32'(`CCD_RST_STACK_TOP));
      rd(`CCD_OFS_STATUS, 32'h6);
      rd(`CCD_OFS_WATCHDOG, 32'h0, 32'hFF00FFFF);
      rd(8'h24, 32'h0, '1, `CCD_RESP_SLVERR);
      rd(8'h06, 32'h0, '1, `CCD_RESP_SLVERR);
      wr(`CCD_OFS_STATUS, 32'hFFFFFFFF, `CCD_RESP_SLVERR);
      rd(`CCD_OFS_STATUS, 32'h6);
      z = 1'b0;
      top_of_stack = 15'h0;
      // Every op with random operands and boundary file values
      for (k = 0; k < 64; k++) begin
         op = k[2:0];
         {fa, d, w, lh, pc} = 38'({$random(seed), $random(seed)});
         v = (k[4:3] == 0) ? 8'h01 : (k[4:3] == 1) ? 8'hFF : (k[4:3] == 2) ? 8'h00 : 8'($random(seed));
         wr(`CCD_OFS_WORK, 32'(w));
         wr(`CCD_OFS_LATCH_HIGH, 32'(lh));
         wr(`CCD_OFS_PC, 32'(pc));
         wr(`CCD_OFS_FILE_PTR, 32'(fa));
         wr(`CCD_OFS_FILE_DATA, 32'(v));
         wr(`CCD_OFS_INSTR, {17'h0, fa, d, 4'h0, op});
         wait_idle();
         res = (op == 3'h4) ? ~v : v - 8'h01;
         top_of_stack = (op == 3'h0) ? pc + 15'h1 : top_of_stack;
         pc = (op == 3'h0) ? {lh, w} : pc + ((op == 3'h6 && res == 8'h0) ? 15'h2 : 15'h1);
         if (op == 3'h1 || op == 3'h2) z = 1'b1;
         if (op == 3'h4 || op == 3'h5) z = (res == 8'h0);
         if (op == 3'h1) v = 8'h0;
         if (op == 3'h2) w = 8'h0;
         if (op >= 3'h4 && op <= 3'h6 && d) v = res;
         if (op >= 3'h4 && op <= 3'h6 && !d) w = res;
         rd(`CCD_OFS_WORK, 32'(w));
         rd(`CCD_OFS_FILE_DATA, 32'(v));
         rd(`CCD_OFS_PC, 32'(pc));
         rd(`CCD_OFS_STACK_TOP, 32'(top_of_stack));
         rd(`CCD_OFS_STATUS, {30'h0, 1'b1, z}, 32'hFFFFFFFB);
      end
      // Watchdog runs out, then the clear op restores it
      repeat (2100) @(posedge i_clock);
      rd(`CCD_OFS_STATUS, 32'h0, 32'h4);
      wr(`CCD_OFS_INSTR, 32'h3);
      wait_idle();
      rd(`CCD_OFS_STATUS, 32'h6, 32'h6);
      // Prescaler has run only a few ticks since the clear
      rd(`CCD_OFS_WATCHDOG, 32'h0, 32'hFFF0FFFF);
      repeat (4) @(posedge i_clock);
      report_and_stop();
   end
endmodule : ccd_exec_core_tb
